// ### logic/eitr_ctrl.sv
// Timer 0 run control plus external interrupt 0/1 detection and pending flags
//
// Our own choices: the register addresses and the strobed register port.
`include "eitr_params.svh"

module eitr_ctrl
   import eitr_pkg::*;
(
   input  wire logic                     clk_sys,
   input  wire logic                     rst_n,
   input  wire eitr_bus_req_type         bus_req,
   output logic      [7:0]               bus_rdata,
   input  wire logic                     ext_irq0_input,
   input  wire logic                     ext_irq1_input,
   input  wire eitr_vec_type             irq_vector_ack,
   output logic                          timer0_count_en,
   output logic                          ext_irq0_request,
   output logic                          ext_irq1_request
);

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------

   // True when a bus address selects the given register
   function automatic logic f_addr_hit(
      input logic [3:0] addr,
      input logic [3:0] ofs
   );
      logic hit;
      hit = (addr == ofs);
      return hit;
   endfunction

   // Pin level folded with polarity: 1 means active
   function automatic logic f_active(
      input logic pin,
      input logic pol
   );
      logic act;
      act = pin ~^ pol;
      return act;
   endfunction

   // Event of one input in the selected detection mode
   function automatic logic f_event(
      input logic is_edge,
      input logic act,
      input logic prev
   );
      logic evt;
      if (is_edge == `EITR_TYPE_EDGE) begin
         evt = act && !prev;
      end else begin
         evt = act;
      end
      return evt;
   endfunction

   // Vectoring clears a flag only for an edge-mode input
   function automatic logic f_vec_clr(
      input eitr_vec_type ack,
      input eitr_vec_type which,
      input logic         is_edge
   );
      logic clr;
      if ((ack == which) && (is_edge == `EITR_TYPE_EDGE)) begin
         clr = 1'b1;
      end else begin
         clr = 1'b0;
      end
      return clr;
   endfunction

   // Next pending value; set wins over write and vector clear
   function automatic logic f_next_pend(
      input logic cur,
      input logic wr_hit,
      input logic wr_bit,
      input logic vec_clr,
      input logic evt
   );
      logic nxt;
      nxt = cur;
      if (wr_hit) begin
         nxt = wr_bit;
      end
      if (vec_clr) begin
         nxt = 1'b0;
      end
      if (evt) begin
         nxt = 1'b1;
      end
      return nxt;
   endfunction

   // Next value of a plain software bit
   function automatic logic f_next_bit(
      input logic cur,
      input logic wr_hit,
      input logic wr_bit
   );
      logic nxt;
      nxt = cur;
      if (wr_hit) begin
         nxt = wr_bit;
      end
      return nxt;
   endfunction

   // Control register as software sees it
   function automatic logic [7:0] f_tctl_view(
      input eitr_ctl_type ctl
   );
      logic [7:0] view;
      view                      = 8'h00;
      view[`EITR_BIT_T0_RUN]    = ctl.timer0_run_bit;
      view[`EITR_BIT_IRQ1_PEND] = ctl.ext_irq1_pending_flag;
      view[`EITR_BIT_IRQ1_TYPE] = ctl.ext_irq1_type_select;
      view[`EITR_BIT_IRQ0_PEND] = ctl.ext_irq0_pending_flag;
      view[`EITR_BIT_IRQ0_TYPE] = ctl.ext_irq0_type_select;
      return view;
   endfunction

   // Status view: current active state of both inputs
   function automatic logic [7:0] f_stat_view(
      input logic act1,
      input logic act0
   );
      logic [7:0] view;
      view    = 8'h00;
      view[0] = act0;
      view[1] = act1;
      return view;
   endfunction

   // Config register keeps only its two polarity bits
   function automatic logic [7:0] f_cfg_mask(
      input logic [7:0] wdata
   );
      logic [7:0] val;
      val                     = `EITR_CFG_RST;
      val[`EITR_BIT_IRQ0_POL] = wdata[`EITR_BIT_IRQ0_POL];
      val[`EITR_BIT_IRQ1_POL] = wdata[`EITR_BIT_IRQ1_POL];
      return val;
   endfunction

   // Read data for one offset; unmapped offsets read 0
   function automatic logic [7:0] f_rd_sel(
      input logic [3:0] addr,
      input logic [7:0] tctl,
      input logic [7:0] cfg,
      input logic [7:0] stat
   );
      logic [7:0] val;
      case (addr)
         `EITR_OFS_TCTL: begin
            val = tctl;
         end
         `EITR_OFS_CFG: begin
            val = cfg;
         end
         `EITR_OFS_STAT: begin
            val = stat;
         end
         default: begin
            val = 8'h00;
         end
      endcase
      return val;
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   eitr_ctl_type ctl_q;
   eitr_ctl_type ctl_d;
   logic [7:0]   cfg_q;
   logic [7:0]   rdata_q;
   logic         irq0_prev_q;
   logic         irq1_prev_q;

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   wire logic       hit_tctl = f_addr_hit(bus_req.addr, `EITR_OFS_TCTL);
   wire logic       hit_cfg  = f_addr_hit(bus_req.addr, `EITR_OFS_CFG);
   wire logic [7:0] wdata    = bus_req.wdata;
   wire logic       wr_tctl  = bus_req.wr && hit_tctl;
   wire logic       wr_cfg   = bus_req.wr && hit_cfg;

   // ------------------------------------------------------------
   // Polarity and activity
   // ------------------------------------------------------------
   wire logic ext_irq0_polarity = cfg_q[`EITR_BIT_IRQ0_POL];
   wire logic ext_irq1_polarity = cfg_q[`EITR_BIT_IRQ1_POL];

   wire logic irq0_act = f_active(ext_irq0_input, ext_irq0_polarity);
   wire logic irq1_act = f_active(ext_irq1_input, ext_irq1_polarity);

   // ------------------------------------------------------------
   // Detection
   // ------------------------------------------------------------
   wire logic irq0_event = f_event(ctl_q.ext_irq0_type_select, irq0_act, irq0_prev_q);
   wire logic irq1_event = f_event(ctl_q.ext_irq1_type_select, irq1_act, irq1_prev_q);

   // ------------------------------------------------------------
   // Vectoring
   // ------------------------------------------------------------
   wire logic vec0_clr = f_vec_clr(irq_vector_ack, EITR_VEC_IRQ0, ctl_q.ext_irq0_type_select);
   wire logic vec1_clr = f_vec_clr(irq_vector_ack, EITR_VEC_IRQ1, ctl_q.ext_irq1_type_select);

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   wire logic [7:0] tctl_view = f_tctl_view(ctl_q);
   wire logic [7:0] stat_view = f_stat_view(irq1_act, irq0_act);
   wire logic [7:0] rd_mux    = f_rd_sel(bus_req.addr, tctl_view, cfg_q, stat_view);
   wire logic [7:0] rd_next   = bus_req.rd ? rd_mux : 8'h00;

   // ------------------------------------------------------------
   // Next values of the control bits
   // ------------------------------------------------------------
   wire logic run_nxt   = f_next_bit(ctl_q.timer0_run_bit, wr_tctl, wdata[`EITR_BIT_T0_RUN]);
   wire logic typ1_nxt  = f_next_bit(ctl_q.ext_irq1_type_select, wr_tctl, wdata[`EITR_BIT_IRQ1_TYPE]);
   wire logic typ0_nxt  = f_next_bit(ctl_q.ext_irq0_type_select, wr_tctl, wdata[`EITR_BIT_IRQ0_TYPE]);
   wire logic pend1_nxt = f_next_pend(ctl_q.ext_irq1_pending_flag, wr_tctl, wdata[`EITR_BIT_IRQ1_PEND],
                                      vec1_clr, irq1_event);
   wire logic pend0_nxt = f_next_pend(ctl_q.ext_irq0_pending_flag, wr_tctl, wdata[`EITR_BIT_IRQ0_PEND],
                                      vec0_clr, irq0_event);

   // ------------------------------------------------------------
   // Next state of control bits
   // ------------------------------------------------------------
   always_comb begin
      ctl_d                       = '0;
      ctl_d.timer0_run_bit        = run_nxt;
      ctl_d.ext_irq1_pending_flag = pend1_nxt;
      ctl_d.ext_irq1_type_select  = typ1_nxt;
      ctl_d.ext_irq0_pending_flag = pend0_nxt;
      ctl_d.ext_irq0_type_select  = typ0_nxt;
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctl_q <= '0;
      end else begin
         ctl_q <= ctl_d;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q <= `EITR_CFG_RST;
      end else if (wr_cfg) begin
         cfg_q <= f_cfg_mask(wdata);
      end
   end

   // ------------------------------------------------------------
   // Edge history
   // ------------------------------------------------------------
   // Resets as active so no edge fires at release
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq0_prev_q <= 1'b1;
      end else begin
         irq0_prev_q <= irq0_act;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq1_prev_q <= 1'b1;
      end else begin
         irq1_prev_q <= irq1_act;
      end
   end

   // Read data stands one cycle, zero otherwise
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rd_next;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign bus_rdata        = rdata_q;
   assign timer0_count_en  = ctl_q.timer0_run_bit;
   assign ext_irq0_request = ctl_q.ext_irq0_pending_flag;
   assign ext_irq1_request = ctl_q.ext_irq1_pending_flag;

endmodule

// ### pkg/eitr_params.svh
// Offsets, bit positions, reset values and detection type constants of the timer/external-irq control block
`ifndef EITR_PARAMS_SVH
`define EITR_PARAMS_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define EITR_ADDR_W          4
`define EITR_OFS_TCTL        4'h0
`define EITR_OFS_CFG         4'h1
`define EITR_OFS_STAT        4'h2

// ------------------------------------------------------------
// Control register bit positions
// ------------------------------------------------------------
`define EITR_BIT_IRQ0_TYPE   0
`define EITR_BIT_IRQ0_PEND   1
`define EITR_BIT_IRQ1_TYPE   2
`define EITR_BIT_IRQ1_PEND   3
`define EITR_BIT_T0_RUN      4

// ------------------------------------------------------------
// Config register bit positions
// ------------------------------------------------------------
`define EITR_BIT_IRQ0_POL    0
`define EITR_BIT_IRQ1_POL    1

// ------------------------------------------------------------
// Reset values and detection type codes
// ------------------------------------------------------------
`define EITR_TCTL_RST        8'h00
`define EITR_CFG_RST         8'h00
`define EITR_TYPE_LEVEL      1'b0
`define EITR_TYPE_EDGE       1'b1

`endif

// ### pkg/eitr_pkg.sv
// Types shared by the timer-run and external-irq control block
package eitr_pkg;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } eitr_bus_req_type;

   typedef struct packed {
      logic timer0_run_bit;
      logic ext_irq1_pending_flag;
      logic ext_irq1_type_select;
      logic ext_irq0_pending_flag;
      logic ext_irq0_type_select;
   } eitr_ctl_type;

   typedef enum logic [1:0] {
      EITR_VEC_NONE = 2'b00,
      EITR_VEC_IRQ0 = 2'b01,
      EITR_VEC_IRQ1 = 2'b10
   } eitr_vec_type;

endpackage

// ### test/eitr_core_model.sv
// Core-side model that vectors to pending external interrupts
module eitr_core_model
   import eitr_pkg::*;
(
   input  wire logic    clk_sys,
   input  wire logic    rst_n,
   input  wire logic    ext_irq0_request,
   input  wire logic    ext_irq1_request,
   output eitr_vec_type irq_vector_ack
);
   timeunit 1ns;
   timeprecision 1ns;
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) irq_vector_ack <= EITR_VEC_NONE;
      else if (irq_vector_ack != EITR_VEC_NONE) irq_vector_ack <= EITR_VEC_NONE;
      else if (ext_irq0_request) irq_vector_ack <= EITR_VEC_IRQ0;
      else if (ext_irq1_request) irq_vector_ack <= EITR_VEC_IRQ1;
   end
endmodule

// ### test/eitr_ctrl_chk.sv
// Assertions on the ports of the control block
module eitr_ctrl_chk
   import eitr_pkg::*;
(
   input wire logic             clk_sys,
   input wire logic             rst_n,
   input wire eitr_bus_req_type bus_req,
   input wire logic [7:0]       bus_rdata,
   input wire logic             ext_irq0_input,
   input wire logic             ext_irq1_input,
   input wire eitr_vec_type     irq_vector_ack,
   input wire logic             timer0_count_en,
   input wire logic             ext_irq0_request,
   input wire logic             ext_irq1_request
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] typ_q;
   logic [1:0] pol_q;
   logic [1:0] act_w;
   logic       nw_w;
   assign nw_w = !bus_req.wr;
   assign act_w = {ext_irq1_input == pol_q[1], ext_irq0_input == pol_q[0]};
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) typ_q <= 2'h0;
      else if (!nw_w && bus_req.addr == 4'h0) typ_q <= {bus_req.wdata[2], bus_req.wdata[0]};
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) pol_q <= 2'h0;
      else if (!nw_w && bus_req.addr == 4'h1) pol_q <= bus_req.wdata[1:0];
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   property p_run; !nw_w && bus_req.addr == 4'h0 |=> timer0_count_en == $past(bus_req.wdata[4]); endproperty
   a_run: assert property (p_run) else $error("run bit");
   property p_lvl0; nw_w && !typ_q[0] && act_w[0] |=> ext_irq0_request; endproperty
   a_lvl0: assert property (p_lvl0) else $error("level irq0");
   property p_lvl1; nw_w && !typ_q[1] && act_w[1] |=> ext_irq1_request; endproperty
   a_lvl1: assert property (p_lvl1) else $error("level irq1");
   property p_edg0; nw_w && $past(nw_w) && $past(rst_n) && typ_q[0] && act_w[0] && !$past(act_w[0])
      |=> ext_irq0_request; endproperty
   a_edg0: assert property (p_edg0) else $error("edge irq0");
   property p_edg1; nw_w && typ_q[1] && !act_w[1] && !ext_irq1_request |=> !ext_irq1_request; endproperty
   a_edg1: assert property (p_edg1) else $error("idle irq1");
   property p_vec; nw_w && typ_q[0] && !act_w[0] && irq_vector_ack == EITR_VEC_IRQ0 |=> !ext_irq0_request;
   endproperty
   a_vec: assert property (p_vec) else $error("vector clear");
endmodule
bind eitr_ctrl eitr_ctrl_chk chk_u (.clk_sys, .rst_n, .bus_req, .bus_rdata, .ext_irq0_input, .ext_irq1_input,
   .irq_vector_ack, .timer0_count_en, .ext_irq0_request, .ext_irq1_request);

// ### test/eitr_ctrl_bench.sv
// Register-level bench of the control block
module eitr_ctrl_bench
   import eitr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic             clk_sys = 1'b0;
   logic             rst_n = 1'b0;
   eitr_bus_req_type bus_req = '0;
   logic [7:0]       bus_rdata;
   logic             irq0 = 1'b1;
   logic             irq1 = 1'b1;
   eitr_vec_type     ack;
   logic             run;
   logic [1:0]       req;
   int               err_total = 0;
   int               compares = 0;
   always #5 clk_sys = ~clk_sys;
   eitr_ctrl dut_u (.clk_sys, .rst_n, .bus_req, .bus_rdata, .ext_irq0_input(irq0), .ext_irq1_input(irq1),
      .irq_vector_ack(ack), .timer0_count_en(run), .ext_irq0_request(req[0]), .ext_irq1_request(req[1]));
   eitr_core_model core_u (.clk_sys, .rst_n, .ext_irq0_request(req[0]), .ext_irq1_request(req[1]),
      .irq_vector_ack(ack));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("mismatches %0d, compares %0d", err_total, compares);
      if (err_total == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys) bus_req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk_sys) bus_req.wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk_sys) bus_req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk_sys) bus_req.rd <= 1'b0;
      #1 chk(bus_rdata, e);
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   initial begin
      #50000;
      err_total++;
      stop_test();
   end
   initial begin
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(4'h0, 8'h00);
      rd(4'hF, 8'h00);
      wr(4'h0, 8'h10);
      chk(run, 1'b1);
      rd(4'h0, 8'h10);
      wr(4'h0, 8'h00);
      chk(run, 1'b0);
      @(posedge clk_sys) irq0 <= 1'b0;
      step(4);
      chk(req, 2'b01);
      @(posedge clk_sys) irq0 <= 1'b1;
      wr(4'h0, 8'h00);
      chk(req, 2'b00);
      wr(4'h0, 8'h05);
      @(posedge clk_sys) irq0 <= 1'b0;
      step(2);
      chk(req, 2'b01);
      step(2);
      chk(req, 2'b00);
      @(posedge clk_sys) irq0 <= 1'b1;
      wr(4'h0, 8'h01);
      @(posedge clk_sys) irq0 <= 1'b0;
      @(posedge clk_sys) irq0 <= 1'b1;
      step(1);
      chk(req, 2'b01);
      step(2);
      chk(req, 2'b00);
      wr(4'h0, 8'h00);
      wr(4'h1, 8'h02);
      rd(4'h1, 8'h02);
      step(3);
      chk(req, 2'b10);
      rd(4'h2, 8'h02);
      @(posedge clk_sys) irq1 <= 1'b0;
      wr(4'h0, 8'h04);
      @(posedge clk_sys) irq1 <= 1'b1;
      step(2);
      chk(req, 2'b10);
      step(2);
      chk(req, 2'b00);
      stop_test();
   end
endmodule
